// File: sfms_pkg.sv
// Constants and types shared by the serial memory slave.
// Overview of operation
// - Chip select high: standby, output off, ignore.
// - Hold low: output off, clock, input ignored.
// - Sample input on rise, shift output on fall.
// - Input carries commands; output carries read data.
// - Serve both clock-idle-low and clock-idle-high modes.
// - Array holds 8192 bytes.
// - Bit 7 guards status writes with pin.
// - Bits 6..4 are spare writable readable bits.
// - Bits 3..2 select the shielded array region.
// - Latch readable; status write leaves it alone.
// - Latch clears at power-up and clear command.
// - Status bit 0 always reads zero.
// - Eight-bit codes; status read, status write.
// - Latch set and latch clear codes.
// - Memory read, write, ident and sleep codes.
// - Reserved code leaves output value undefined.
// - Partial command code at deselect does nothing.
// - Latch set command sets the latch.
// - Guard pair maps to none, quarter, half, all.
// - Writes need latch; status needs pin high or enable clear.
// - Sixteen-bit address, top ignored, wrapping increment.
package sfms_pkg;
   localparam int unsigned ADDR_W         = 13;
   localparam int unsigned DEPTH          = 8192;
   localparam int unsigned HI_ADDR_BITS   = 5;
   localparam int unsigned BYTE_MSB       = 7;
   localparam logic [2:0]  BIT_LAST       = 3'h7;
   localparam logic [1:0]  ID_LAST        = 2'h3;
   localparam logic [12:0] ADDR_LAST      = 13'h1fff;
   localparam logic [12:0] GUARD_QTR_BASE = 13'h1800;
   localparam logic [12:0] GUARD_HLF_BASE = 13'h1000;
   localparam logic [1:0]  GUARD_NONE     = 2'h0;
   localparam logic [1:0]  GUARD_QTR      = 2'h1;
   localparam logic [1:0]  GUARD_HLF      = 2'h2;
   localparam logic [7:0]  LATCH_SET_CMD    = 8'h06;
   localparam logic [7:0]  LATCH_CLEAR_CMD  = 8'h04;
   localparam logic [7:0]  STATUS_READ_CMD  = 8'h05;
   localparam logic [7:0]  STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0]  MEM_READ_CMD     = 8'h03;
   localparam logic [7:0]  MEM_WRITE_CMD    = 8'h02;
   localparam logic [7:0]  IDENT_READ_CMD   = 8'h9f;
   localparam logic [7:0]  SLEEP_CMD        = 8'hb9;
   localparam logic [7:0]  RESERVED_CMD     = 8'h0b;
   localparam int unsigned REC_TIME_US    = 400;
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned REC_CYCLES     = REC_TIME_US * CLK_MHZ;
   typedef struct packed {
      logic       status_guard_enable;
      logic [2:0] spare;
      logic       region_guard_hi;
      logic       region_guard_lo;
      logic       write_enable_latch;
      logic       zero;
   } sfms_status_t;
   localparam sfms_status_t STATUS_RESET = 8'h00;
   typedef enum logic [3:0] {
      ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_MEM_READ, ST_MEM_WRITE,
      ST_STAT_READ, ST_STAT_WRITE, ST_IDENT, ST_IGNORE
   } sfms_state_t;
endpackage : sfms_pkg

// File: sfms_top.sv
// Serial memory slave: command decoder, status register, array and sleep control.
`timescale 1ns/1ps
module sfms_top
   import sfms_pkg::*;
#(
   parameter logic [3:0][7:0] IDENT_CODE = 32'h1234_5678, // Arbitrary value.
   parameter int unsigned     REC_CYC    = REC_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic sck_i,
   input  wire logic cs_n_i,
   input  wire logic si_i,
   input  wire logic hold_n_i,
   input  wire logic wp_n_i,
   output logic      so_o,
   output logic      so_oe_o,
   output logic      asleep_o
);
   localparam int unsigned REC_W = $clog2(REC_CYC + 1);

   logic [1:0]   rst_q;
   logic         rst_n;
   logic         frame_rst_n;
   logic         oe_rst_n;
   sfms_state_t  state;
   sfms_state_t  next_state;
   logic [2:0]   bit_cnt;
   logic [6:0]   rx_sh;
   logic [7:0]   rx_byte;
   logic         byte_done;
   logic         op_done;
   logic         is_write;
   logic [12:0]  addr;
   logic [7:0]   mem [DEPTH];
   sfms_status_t status;
   sfms_status_t wr_val;
   logic         guarded;
   logic         mem_we;
   logic         stat_we;
   logic [1:0]   wp_q;
   logic         sleep_armed;
   logic [1:0]   id_idx;
   logic         id_end;
   logic [7:0]   load_byte;
   logic [6:0]   tx_sh;
   logic         reading;
   logic [1:0]   cs_sync;
   logic [1:0]   arm_sync;
   logic         arm_taken;
   logic         cs_seen;
   logic [REC_W-1:0] rec_cnt;

   // Reset release through two flip-flops.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'h1};
      end
   end
   assign rst_n = rst_q[1];

   // Deselect clears all frame state; hold also forces the output off.
   assign frame_rst_n = rst_n & ~cs_n_i;
   assign oe_rst_n    = frame_rst_n & hold_n_i;

   // Incoming bits are taken most significant first.
   assign rx_byte   = {rx_sh, si_i};
   assign byte_done = (bit_cnt == BIT_LAST);
   assign op_done   = byte_done && hold_n_i && (state == ST_OPCODE);
   assign wr_val    = sfms_status_t'(rx_byte);

   // Bit counter and input shifter run on the rising clock edge.
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt <= 3'h0;
         rx_sh   <= 7'h00;
      end else if (hold_n_i) begin
         bit_cnt <= bit_cnt + 3'h1;
         rx_sh   <= rx_byte[6:0];
      end
   end

   // Command decode picks the phase that follows each byte.
   always_comb begin
      next_state = state;
      case (state)
         ST_OPCODE: begin
            case (rx_byte)
               STATUS_READ_CMD:  next_state = ST_STAT_READ;
               STATUS_WRITE_CMD: next_state = ST_STAT_WRITE;
               MEM_READ_CMD:     next_state = ST_ADDR_HI;
               MEM_WRITE_CMD:    next_state = ST_ADDR_HI;
               IDENT_READ_CMD:   next_state = ST_IDENT;
               default:          next_state = ST_IGNORE;
            endcase
         end
         ST_ADDR_HI:    next_state = ST_ADDR_LO;
         ST_ADDR_LO:    next_state = is_write ? ST_MEM_WRITE : ST_MEM_READ;
         ST_STAT_WRITE: next_state = ST_IGNORE;
         default:       next_state = state;
      endcase
   end

   // Phase register and write flag live only for one frame.
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state    <= ST_OPCODE;
         is_write <= 1'h0;
      end else if (hold_n_i && byte_done) begin
         state <= next_state;
         if (state == ST_OPCODE) begin
            is_write <= (rx_byte == MEM_WRITE_CMD);
         end
      end
   end

   // Address load drops the upper three bits and wraps on increment.
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         addr <= 13'h0000;
      end else if (hold_n_i && byte_done) begin
         case (state)
            ST_ADDR_HI:   addr[ADDR_W-1:8] <= rx_byte[HI_ADDR_BITS-1:0];
            ST_ADDR_LO:   addr[7:0] <= rx_byte;
            ST_MEM_READ:  addr <= addr + 13'h0001;
            ST_MEM_WRITE: addr <= addr + 13'h0001;
            default:      addr <= addr;
         endcase
      end
   end

   // Region shielded from array writes.
   always_comb begin
      case ({status.region_guard_hi, status.region_guard_lo})
         GUARD_NONE: guarded = 1'h0;
         GUARD_QTR:  guarded = (addr >= GUARD_QTR_BASE);
         GUARD_HLF:  guarded = (addr >= GUARD_HLF_BASE);
         default:    guarded = 1'h1;
      endcase
   end

   // Array writes follow the latch and the region guard; status writes follow the latch, the guard enable and the pin.
   assign mem_we  = hold_n_i && byte_done && (state == ST_MEM_WRITE)
                    && status.write_enable_latch && !guarded;
   assign stat_we = hold_n_i && byte_done && (state == ST_STAT_WRITE)
                    && status.write_enable_latch
                    && !(status.status_guard_enable && !wp_q[1]);

   // Array storage of one byte per location.
   always_ff @(posedge sck_i) begin
      if (mem_we) begin
         mem[addr] <= rx_byte;
      end
   end

   // The protect pin is fixed around a status write, so it is simply synchronised.
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 2'h0;
      end else begin
         wp_q <= {wp_q[0], wp_n_i};
      end
   end

   // Status register: latch by command, other bits by status write.
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         status <= STATUS_RESET;
      end else if (op_done && rx_byte == LATCH_SET_CMD) begin
         status.write_enable_latch <= 1'h1;
      end else if (op_done && rx_byte == LATCH_CLEAR_CMD) begin
         status.write_enable_latch <= 1'h0;
      end else if (stat_we) begin
         status.status_guard_enable <= wr_val.status_guard_enable;
         status.spare               <= wr_val.spare;
         status.region_guard_hi     <= wr_val.region_guard_hi;
         status.region_guard_lo     <= wr_val.region_guard_lo;
      end
   end

   // Sleep is armed by its code and cancelled by any later clock taken while selected with hold high.
   always_ff @(posedge sck_i or negedge rst_n) begin
      if (!rst_n) begin
         sleep_armed <= 1'h0;
      end else if (hold_n_i && !cs_n_i) begin
         sleep_armed <= op_done && (rx_byte == SLEEP_CMD);
      end
   end

   // Identification byte index; the last bit is held once all are sent.
   always_ff @(posedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         id_idx <= 2'h0;
         id_end <= 1'h0;
      end else if (hold_n_i && byte_done && state == ST_IDENT) begin
         id_idx <= id_idx + 2'h1;
         id_end <= id_end || (id_idx == ID_LAST);
      end
   end

   // Byte offered to the output shifter at each byte boundary.
   always_comb begin
      case (state)
         ST_STAT_READ: load_byte = status;
         ST_MEM_READ:  load_byte = mem[addr];
         ST_IDENT:     load_byte = IDENT_CODE[ID_LAST - id_idx];
         default:      load_byte = 8'h00;
      endcase
   end
   assign reading = (state == ST_STAT_READ) || (state == ST_MEM_READ)
                    || (state == ST_IDENT);

   // Output data changes on the falling edge, which serves both clock polarities.
   always_ff @(negedge sck_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         so_o  <= 1'h0;
         tx_sh <= 7'h00;
      end else if (!hold_n_i || (state == ST_IDENT && id_end)) begin
         so_o  <= so_o;
         tx_sh <= tx_sh;
      end else if (bit_cnt == 3'h0) begin
         so_o  <= load_byte[BYTE_MSB];
         tx_sh <= load_byte[BYTE_MSB-1:0];
      end else begin
         so_o  <= tx_sh[BYTE_MSB-1];
         tx_sh <= {tx_sh[BYTE_MSB-2:0], 1'h0};
      end
   end

   // Output enable drops at once on deselect or hold.
   always_ff @(negedge sck_i or negedge oe_rst_n) begin
      if (!oe_rst_n) begin
         so_oe_o <= 1'h0;
      end else begin
         so_oe_o <= reading;
      end
   end

   // Chip select and the sleep arm cross into the system clock.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_sync  <= 2'h3;
         arm_sync <= 2'h0;
         cs_seen  <= 1'h1;
      end else begin
         cs_sync  <= {cs_sync[0], cs_n_i};
         arm_sync <= {arm_sync[0], sleep_armed};
         cs_seen  <= cs_sync[1];
      end
   end

   // Marks a sleep arm as used, so that an empty frame during recovery
   // cannot send the block back to sleep; the link drops the arm at its next clock.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         arm_taken <= 1'h0;
      end else if (!arm_sync[1]) begin
         arm_taken <= 1'h0;
      end else if (cs_sync[1] && !cs_seen) begin
         arm_taken <= 1'h1;
      end
   end

   // Sleep begins at deselect and ends a recovery time after reselect.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         asleep_o <= 1'h0;
         rec_cnt  <= '0;
      end else if (cs_sync[1] && !cs_seen && arm_sync[1] && !arm_taken) begin
         asleep_o <= 1'h1;
         rec_cnt  <= '0;
      end else if (asleep_o && !cs_sync[1] && cs_seen) begin
         rec_cnt <= REC_W'(REC_CYC);
      end else if (rec_cnt != '0) begin
         rec_cnt <= rec_cnt - REC_W'(1);
         if (rec_cnt == REC_W'(1)) begin
            asleep_o <= 1'h0;
         end
      end
   end

   // Checks on the link clock.
   latch_set_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      op_done && rx_byte == LATCH_SET_CMD |=> status.write_enable_latch)
      else $error("latch not set by set command");
   latch_clr_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      op_done && rx_byte == LATCH_CLEAR_CMD |=> !status.write_enable_latch)
      else $error("latch not cleared by clear command");
   stat_latch_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      hold_n_i && byte_done && state == ST_STAT_WRITE
      |=> status.write_enable_latch == $past(status.write_enable_latch))
      else $error("status write changed the latch");
   stat_zero_a: assert property (@(posedge sck_i) disable iff (!rst_n)
      state == ST_STAT_READ |-> !load_byte[0])
      else $error("status bit zero not zero");
   guard_write_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      mem_we |-> status.write_enable_latch
      && !(status.region_guard_hi && status.region_guard_lo))
      else $error("array write while protected");
   guard_qtr_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      !status.region_guard_hi && status.region_guard_lo && addr < GUARD_QTR_BASE
      && state == ST_MEM_WRITE && byte_done && hold_n_i
      && status.write_enable_latch |-> mem_we)
      else $error("unguarded write refused");
   addr_wrap_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      hold_n_i && byte_done && state == ST_MEM_READ && addr == ADDR_LAST
      |=> addr == 13'h0000)
      else $error("address did not wrap");
   stat_guard_a: assert property (@(posedge sck_i) disable iff (!frame_rst_n)
      stat_we |-> !status.status_guard_enable || wp_q[1])
      else $error("status write while guarded");
   // Checks on the system clock, then cover points on both clocks.
   standby_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cs_n_i |-> !so_oe_o)
      else $error("output driven while deselected");
   hold_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !hold_n_i |-> !so_oe_o)
      else $error("output driven during hold");
   sleep_in_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      cs_sync[1] && !cs_seen && arm_sync[1] && !arm_taken |=> asleep_o)
      else $error("sleep not entered");
   stat_rd_c: cover property (@(posedge sck_i) state == ST_STAT_READ && byte_done);
   mem_wr_c: cover property (@(posedge sck_i) mem_we);
   ident_c: cover property (@(posedge sck_i) id_end);
   sleep_c: cover property (@(posedge clk_i) asleep_o);
endmodule : sfms_top

// File: sfms_host_model.sv
// Host serial master model that drives the link pins of the memory slave.
`timescale 1ns/1ps
module sfms_host_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   output logic      hold_n_o,
   input  wire logic so_i
);
   localparam time HALF = 16ns;
   logic           mode3;

   // The link idles deselected with the clock low.
   initial begin
      mode3    = 1'b0;
      sck_o    = 1'b0;
      cs_n_o   = 1'b1;
      si_o     = 1'b0;
      hold_n_o = 1'b1;
   end

   // Parks the clock at the idle level of the mode, then selects the slave.
   task automatic open_frame(input logic m3);
      mode3 = m3;
      sck_o = m3;
      #(HALF);
      cs_n_o = 1'b0;
      #(HALF);
   endtask : open_frame

   // Shifts n bits out most significant first and samples the reply on each rise.
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         sck_o = 1'b0;
         si_o  = tx[7-i];
         #(HALF);
         sck_o = 1'b1;
         rx    = {rx[6:0], so_i};
         #(HALF);
      end
   endtask : shift

   // Moves the hold pin while the select stays low, so no command is lost.
   task automatic set_hold(input logic v);
      hold_n_o = v;
      #(HALF);
   endtask : set_hold

   // Returns the clock to idle, deselects and stops showing the last data value.
   task automatic close_frame();
      sck_o = mode3;
      #(HALF);
      cs_n_o = 1'b1;
      si_o   = ~si_o;
      #(2*HALF);
   endtask : close_frame
endmodule : sfms_host_model

// File: test_spi_ferro_memory_slave.sv
// Self-checking bench for the serial memory slave driven by a host master model.
`timescale 1ns/1ps
module test_spi_ferro_memory_slave;
   import sfms_pkg::*;
   typedef struct packed {
      logic       m3;
      logic       wp_n;
      logic [7:0] pre;
      logic [7:0] val;
      logic [7:0] exp;
   } sfms_row_t;
   // Only listed command codes are ever sent.
   localparam sfms_row_t ROWS [5] = '{
      '{1'b0, 1'b1, LATCH_SET_CMD, 8'hff, 8'hfe},
      '{1'b1, 1'b0, LATCH_SET_CMD, 8'h00, 8'hfe},
      '{1'b1, 1'b1, LATCH_SET_CMD, 8'h00, 8'h02},
      '{1'b0, 1'b1, LATCH_CLEAR_CMD, 8'h8c, 8'h00},
      '{1'b0, 1'b0, LATCH_SET_CMD, 8'h8c, 8'h8e}};
   // Arbitrary identification value given to the slave.
   localparam logic [31:0] ID_VAL = 32'h1234_5678;
   logic        clk_i;
   logic        rstn_i;
   logic        wp_n_i;
   wire         sck, cs_n, si, hold_n, so_w;
   logic        so, so_oe, asleep;
   logic [31:0] rx;
   logic [7:0]  a, b;
   int          error_cnt    = 0;
   int          total_checks = 0;

   // The data wire floats whenever the slave does not drive it.
   assign so_w = so_oe ? so : 1'bz;

   sfms_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so_w));
   sfms_top #(.IDENT_CODE(ID_VAL), .REC_CYC(20)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so),
      .so_oe_o(so_oe), .asleep_o(asleep));

   // The system clock toggles every 10 ns, giving a period of 20 ns.
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Compares a seen value with the expected one and counts both outcomes.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test

   // Runs one whole frame of n bytes and keeps the last four bytes received.
   task automatic frame(input logic m3, input logic [47:0] tx, input int n,
                        output logic [31:0] r);
      logic [7:0] t;
      r = 32'h0;
      host.open_frame(m3);
      for (int i = 0; i < n; i++) begin
         host.shift(tx[47-8*i -: 8], 8, t);
         r = {r[23:0], t};
      end
      host.close_frame();
   endtask : frame

   // Waits a bounded time for the sleep flag to reach a level.
   task automatic wait_sleep(input logic v);
      int k;
      for (k = 0; k < 200 && asleep !== v; k++) @(negedge clk_i);
      if (k == 200) begin
         error_cnt++;
         $display("unexpected at %0t: sleep flag stuck", $time);
         stop_test();
      end
   endtask : wait_sleep

   // Applies reset through the clock edge and leaves time for its release.
   task automatic do_reset();
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask : do_reset

   // Main sequence: status rows first, then array, ident, abort, hold, sleep, reset.
   initial begin
      rstn_i <= 1'b0;
      wp_n_i <= 1'b1;
      do_reset();
      foreach (ROWS[i]) begin
         @(posedge clk_i);
         wp_n_i <= ROWS[i].wp_n;
         frame(ROWS[i].m3, {ROWS[i].pre, 40'h0}, 1, rx);
         frame(ROWS[i].m3, {STATUS_WRITE_CMD, ROWS[i].val, 32'h0}, 2, rx);
         frame(ROWS[i].m3, {STATUS_READ_CMD, 40'h0}, 3, rx);
         check({16'h0, rx[15:0]}, {16'h0, ROWS[i].exp, ROWS[i].exp});
      end
      @(posedge clk_i);
      wp_n_i <= 1'b1;
      frame(1'b0, {LATCH_SET_CMD, 40'h0}, 1, rx);
      frame(1'b0, {STATUS_WRITE_CMD, 40'h0}, 2, rx);
      frame(1'b0, {MEM_WRITE_CMD, 16'hffff, 8'ha5, 8'h5a, 8'h00}, 5, rx);
      frame(1'b1, {MEM_READ_CMD, 16'h3fff, 16'h0000, 8'h00}, 5, rx);
      check({16'h0, rx[15:0]}, 32'h0000_a55a);
      frame(1'b0, {MEM_WRITE_CMD, 16'h17ff, 8'h33, 8'h33, 8'h00}, 5, rx);
      frame(1'b0, {STATUS_WRITE_CMD, 8'h04, 32'h0}, 2, rx);
      frame(1'b0, {MEM_WRITE_CMD, 16'h17ff, 8'h11, 8'h22, 8'h00}, 5, rx);
      frame(1'b0, {MEM_READ_CMD, 16'h17ff, 16'h0000, 8'h00}, 5, rx);
      check({16'h0, rx[15:0]}, 32'h0000_1133);
      frame(1'b0, {IDENT_READ_CMD, 40'h0}, 6, rx);
      check(rx, {ID_VAL[23:0], {8{ID_VAL[0]}}});
      frame(1'b0, {LATCH_CLEAR_CMD, 40'h0}, 1, rx);
      host.open_frame(1'b0);
      host.shift(LATCH_SET_CMD, 7, a);
      host.close_frame();
      host.open_frame(1'b0);
      host.shift(STATUS_READ_CMD, 8, a);
      host.shift(8'h00, 4, a);
      host.set_hold(1'b0);
      check({31'h0, so_oe}, 32'h0);
      host.shift(8'hff, 3, b);
      host.set_hold(1'b1);
      host.shift(8'h00, 4, b);
      host.close_frame();
      check({24'h0, a[3:0], b[3:0]}, 32'h04);
      check({31'h0, so_oe}, 32'h0);
      host.open_frame(1'b0);
      host.shift(RESERVED_CMD, 8, a);
      host.shift(8'h00, 8, a);
      check({31'h0, so_oe}, 32'h0);
      host.close_frame();
      frame(1'b0, {SLEEP_CMD, 40'h0}, 1, rx);
      wait_sleep(1'b1);
      check({31'h0, asleep}, 32'h1);
      host.open_frame(1'b0);
      host.close_frame();
      wait_sleep(1'b0);
      check({31'h0, asleep}, 32'h0);
      do_reset();
      check({31'h0, so_oe}, 32'h0);
      frame(1'b0, {STATUS_READ_CMD, 40'h0}, 2, rx);
      check({24'h0, rx[7:0]}, {24'h0, STATUS_RESET});
      stop_test();
   end
endmodule : test_spi_ferro_memory_slave
